/* adc_seq_cfg.svh */
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// Conversion timing, in converter-clock cycles
`define RES_BITS 10
`define CYC_NOSH_8 49
`define CYC_NOSH_10 59
`define SMP_NOSH 2
`define CYC_SH_8 28
`define CYC_SH_10 33
`define SMP_SH 3
// Reference settle time after connect
`define REF_SETTLE_NS 1000
`define CLK_PERIOD_NS 8
`define REF_SETTLE_CYC ((`REF_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESULT_RESET 10'h000
`define NUM_RESULTS 8

`endif

/* adc_seq_pkg.sv */
`default_nettype none

package adc_seq_pkg;

    typedef enum logic [2:0] {
        MODE_ONE_SHOT = 3'b000,
        MODE_REPEAT = 3'b001,
        MODE_SWEEP = 3'b010,
        MODE_REP_SWEEP0 = 3'b011,
        MODE_REP_SWEEP1 = 3'b111
    } op_mode_t;

    typedef struct packed {
        logic conv_start_set;
        logic conv_start_clr;
        logic trigger_type_sel;
        logic trigger_source_hi;
        logic trigger_source_lo;
        logic clk_div_sel_a;
        logic clk_div_sel_b;
        logic clk_div_sel_hi;
        logic op_mode_hi;
        logic op_mode_lo;
        logic repeat_sweep1_sel;
        logic sweep_range_hi;
        logic sweep_range_lo;
        logic ext_input_sel_hi;
        logic ext_input_sel_lo;
        logic multiport_sweep_en;
        logic dma_result_mode;
        logic port_group_hi;
        logic port_group_lo;
        logic [2:0] channel_sel;
        logic ref_connect;
        logic res_10bit;
        logic sample_hold;
    } adc_ctrl_t;

    typedef struct packed {
        logic [1:0] port;
        logic [2:0] pin;
        logic [1:0] ext;
    } adc_sel_t;

endpackage

`default_nettype wire

/* sar_adc_sequencer_control.sv */
// Summary of operation
// - One 10-bit SAR converter, one bit decision per step.
// - Result goes to the selected pin's register; DMA mode uses first register only.
// - Reference ladder disconnected while ref_connect is 0.
// - Conversion clock divides source by 4,3,2,1 or 8,6 from three select bits.
// - Five mode codes: one-shot, repeat, single sweep, repeat sweep 0 and 1, where 1 runs as 0; multi-port sweep by enable bit.
// - 34 inputs: four ports of eight pins plus two extended inputs.
// - Software trigger starts conversion when conv_start is written 1.
// - External trigger: falling edge of trigger pin starts or restarts conversion.
// - Hardware trigger: timer B2 thinned or timer A0 interrupt starts; retrigger allowed.
// - Without sample-hold: 49 or 59 cycles, 2 sampling.
// - With sample-hold: 28 or 33 cycles, 3 sampling.
// - Control rewrites during conversion may give undefined results.
// - Channel select only used in one-shot and repeat modes.
// - Multi-port-only control acts only with multi-port sweep enabled.
// - One-shot software trigger clears conv_start on completion; software may clear.
// - Interrupt request pulses when a one-shot conversion completes.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_cfg.svh"

module sar_adc_sequencer_control (
    input wire logic mclk,
    input wire logic rstn,
    input wire adc_seq_pkg::adc_ctrl_t ctrl,
    input wire logic ext_trigger_pin,
    input wire logic timer_b2_thin_irq,
    input wire logic timer_a0_irq,
    input wire logic comparator_out,
    input wire logic multiport_ctrl_in,
    output logic conv_start,
    output logic busy,
    output logic ref_connected,
    output logic conv_clk_en,
    output logic sampling,
    output adc_seq_pkg::adc_sel_t sel,
    output logic [9:0] dac_code,
    output logic [9:0] result [`NUM_RESULTS],
    output logic [2:0] result_wr_idx,
    output logic result_wr,
    output logic conv_irq,
    output logic dma_req,
    output logic multiport_ctrl_out
);
    import adc_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock divider

    logic [2:0] div_cnt;
    logic [2:0] div_max;
    wire [2:0] cks = {ctrl.clk_div_sel_hi, ctrl.clk_div_sel_a, ctrl.clk_div_sel_b};

    always_comb begin
        unique case (cks)
            3'b000: div_max = 3'h3;
            3'b001: div_max = 3'h2;
            3'b010: div_max = 3'h1;
            3'b011: div_max = 3'h0;
            3'b100: div_max = 3'h7;
            3'b101: div_max = 3'h5;
            default: div_max = 3'h7;
        endcase
    end

    wire tick = (div_cnt >= div_max);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= tick ? 3'h0 : div_cnt + 3'h1;
        end
    end

    assign conv_clk_en = tick;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and trigger edges

    logic [1:0] trg_s1, trg_s2;
    logic [1:0] trg_d;
    logic [1:0] ext_s;
    logic ext_d;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ext_s <= 2'h3;
            ext_d <= 1'b1;
            trg_s1 <= 2'h0;
            trg_s2 <= 2'h0;
            trg_d <= 2'h0;
        end else begin
            ext_s <= {ext_s[0], ext_trigger_pin};
            ext_d <= ext_s[1];
            trg_s1 <= {timer_a0_irq, timer_b2_thin_irq};
            trg_s2 <= trg_s1;
            trg_d <= trg_s2;
        end
    end

    wire ext_fall = ext_d & ~ext_s[1];
    wire [1:0] trg_rise = trg_s2 & ~trg_d;
    wire [1:0] trg_src = {ctrl.trigger_source_hi, ctrl.trigger_source_lo};

    wire hw_event = ctrl.trigger_type_sel & conv_start & (
        (trg_src == 2'b00 && ext_fall) ||
        (trg_src == 2'b01 && trg_rise[0]) ||
        (trg_src == 2'b10 && trg_rise[1]));

    ////////////////////////////////////////////////////////////////////////
    // Reference connect and settle timer

    logic [7:0] settle_cnt;
    wire ref_ready = ctrl.ref_connect && settle_cnt == 8'(`REF_SETTLE_CYC);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            settle_cnt <= 8'h00;
        end else if (!ctrl.ref_connect) begin
            settle_cnt <= 8'h00;
        end else if (!ref_ready) begin
            settle_cnt <= settle_cnt + 8'h01;
        end
    end

    assign ref_connected = ctrl.ref_connect;

    ////////////////////////////////////////////////////////////////////////
    // Mode and selection decode

    wire [2:0] mode_bits = {ctrl.repeat_sweep1_sel, ctrl.op_mode_hi, ctrl.op_mode_lo};
    wire single_pin = ~ctrl.op_mode_hi;
    wire one_shot = mode_bits[1:0] == 2'b00;
    wire repeating = ctrl.op_mode_lo;
    wire [2:0] last_pin = ctrl.multiport_sweep_en ? 3'h7 :
        ({ctrl.sweep_range_hi, ctrl.sweep_range_lo} == 2'b00) ? 3'h1 :
        ({ctrl.sweep_range_hi, ctrl.sweep_range_lo} == 2'b01) ? 3'h3 :
        ({ctrl.sweep_range_hi, ctrl.sweep_range_lo} == 2'b10) ? 3'h5 : 3'h7;

    logic [5:0] cycle_len;
    logic [1:0] samp_len;
    always_comb begin
        unique case ({ctrl.sample_hold, ctrl.res_10bit})
            2'b00: cycle_len = 6'(`CYC_NOSH_8);
            2'b01: cycle_len = 6'(`CYC_NOSH_10);
            2'b10: cycle_len = 6'(`CYC_SH_8);
            2'b11: cycle_len = 6'(`CYC_SH_10);
        endcase
        samp_len = ctrl.sample_hold ? 2'(`SMP_SH) : 2'(`SMP_NOSH);
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10,
        ST_DONE = 2'b11
    } seq_state_t;

    seq_state_t state;
    logic [5:0] cyc;
    logic [3:0] bit_idx;
    logic [2:0] pin;
    logic [9:0] sar;
    logic port_mp;

    wire sw_go = ~ctrl.trigger_type_sel & ctrl.conv_start_set;
    wire go = (sw_go | hw_event) & ref_ready;
    wire conv_end = tick && cyc == cycle_len - 6'h1;
    wire [9:0] trial = sar | (10'h200 >> bit_idx);
    wire last_of_seq = single_pin | (pin == last_pin);
    wire [3:0] bits_used = ctrl.res_10bit ? 4'd10 : 4'd8;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            conv_start <= 1'b0;
        end else if (ctrl.conv_start_set) begin
            conv_start <= 1'b1;
        end else if (ctrl.conv_start_clr) begin
            conv_start <= 1'b0;
        end else if (state == ST_DONE && one_shot && !ctrl.trigger_type_sel) begin
            conv_start <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            cyc <= 6'h00;
            bit_idx <= 4'h0;
            pin <= 3'h0;
            sar <= 10'h000;
            port_mp <= 1'b0;
        end else if (ctrl.conv_start_clr || !ctrl.ref_connect) begin
            state <= ST_IDLE;
        end else if (go) begin
            state <= ST_SAMPLE;
            cyc <= 6'h00;
            pin <= single_pin ? ctrl.channel_sel : 3'h0;
            port_mp <= 1'b0;
            sar <= 10'h000;
            bit_idx <= 4'h0;
        end else begin
            unique case (state)
                ST_IDLE: ;
                ST_SAMPLE: if (tick) begin
                    cyc <= cyc + 6'h01;
                    if (cyc == {4'h0, samp_len} - 6'h01) begin
                        state <= ST_CONVERT;
                    end
                end
                ST_CONVERT: if (tick) begin
                    cyc <= cyc + 6'h01;
                    if (bit_idx < bits_used) begin
                        sar <= comparator_out ? trial : sar;
                        bit_idx <= bit_idx + 4'h1;
                    end
                    if (conv_end) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    cyc <= 6'h00;
                    bit_idx <= 4'h0;
                    sar <= 10'h000;
                    if (ctrl.multiport_sweep_en && pin == 3'h7 && !port_mp) begin
                        port_mp <= 1'b1;
                        pin <= 3'h0;
                        state <= ST_SAMPLE;
                    end else if (!last_of_seq) begin
                        pin <= pin + 3'h1;
                        state <= ST_SAMPLE;
                    end else if (repeating) begin
                        pin <= single_pin ? ctrl.channel_sel : 3'h0;
                        port_mp <= 1'b0;
                        state <= ST_SAMPLE;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign busy = state != ST_IDLE;
    assign sampling = state == ST_SAMPLE;
    assign dac_code = trial;
    wire [1:0] sel_port = port_mp ? 2'b00 : {ctrl.port_group_hi, ctrl.port_group_lo};
    assign sel = {sel_port, pin, ctrl.ext_input_sel_hi, ctrl.ext_input_sel_lo};
    assign multiport_ctrl_out = ctrl.multiport_sweep_en & multiport_ctrl_in;

    ////////////////////////////////////////////////////////////////////////
    // Result storage and completion events

    wire store = state == ST_DONE;
    wire [2:0] wr_idx = ctrl.dma_result_mode ? 3'h0 : pin;
    wire [9:0] aligned = ctrl.res_10bit ? sar : {2'b00, sar[9:2]};

    generate
        for (genvar i = 0; i < `NUM_RESULTS; i++) begin : g_res
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    result[i] <= `RESULT_RESET;
                end else if (store && wr_idx == 3'(i)) begin
                    result[i] <= aligned;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            result_wr <= 1'b0;
            result_wr_idx <= 3'h0;
            conv_irq <= 1'b0;
            dma_req <= 1'b0;
        end else begin
            result_wr <= store;
            result_wr_idx <= wr_idx;
            conv_irq <= store & one_shot;
            dma_req <= store & ctrl.dma_result_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence oneshot_done_s;
        state == ST_DONE && one_shot;
    endsequence

    start_on_sw_a: assert property (@(posedge mclk) disable iff (!rstn)
        sw_go && ref_ready && ctrl.ref_connect && !ctrl.conv_start_clr |=> state == ST_SAMPLE)
        else $error("software start missed");
    oneshot_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
        state == ST_DONE && one_shot && !ctrl.trigger_type_sel && !ctrl.conv_start_set
        |=> !conv_start)
        else $error("start bit not cleared");
    irq_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
        oneshot_done_s |=> conv_irq)
        else $error("missing completion interrupt");
    dma_req_a: assert property (@(posedge mclk) disable iff (!rstn)
        dma_req |-> $past(ctrl.dma_result_mode) && result_wr_idx == 3'h0)
        else $error("dma request wrong");
    dma_slot_a: assert property (@(posedge mclk) disable iff (!rstn)
        result_wr && result_wr_idx != 3'h0 |-> !$past(ctrl.dma_result_mode))
        else $error("dma result misplaced");
    ref_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
        !ctrl.ref_connect |=> !busy)
        else $error("running without reference");
    div_bound_a: assert property (@(posedge mclk) disable iff (!rstn)
        div_cnt <= div_max || $past(div_max) != div_max)
        else $error("divider overrun");
    bit_bound_a: assert property (@(posedge mclk) disable iff (!rstn)
        bit_idx <= 4'd10)
        else $error("too many bit decisions");
    ext_edge_a: assert property (@(posedge mclk) disable iff (!rstn)
        hw_event && ref_ready && ctrl.ref_connect && !ctrl.conv_start_clr
        |=> state == ST_SAMPLE)
        else $error("trigger edge ignored");
    conv_len_a: assert property (@(posedge mclk) disable iff (!rstn)
        state == ST_CONVERT |-> cyc < cycle_len)
        else $error("conversion too long");

endmodule

`default_nettype wire

/* analog_front_model.sv */
`timescale 1ns/1ps
`default_nettype none

module analog_front_model (
    input wire logic mclk,
    input wire logic [9:0] dac_code,
    input wire adc_seq_pkg::adc_sel_t sel,
    input wire logic [9:0] level [8],
    output logic comparator_out,
    output logic ext_trigger_pin,
    output logic timer_b2_thin_irq,
    output logic timer_a0_irq
);
    import adc_seq_pkg::*;

    // Decision is keep when the pin level reaches the trial code
    assign comparator_out = (level[sel.pin] >= dac_code);

    initial begin
        ext_trigger_pin = 1'b1;
        timer_b2_thin_irq = 1'b0;
        timer_a0_irq = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulses last three clocks so a two-stage synchroniser cannot miss them
    task automatic fire(input logic [1:0] src);
        @(posedge mclk);
        case (src)
            2'b00: ext_trigger_pin <= 1'b0;
            2'b01: timer_b2_thin_irq <= 1'b1;
            default: timer_a0_irq <= 1'b1;
        endcase
        repeat (3) @(posedge mclk);
        ext_trigger_pin <= 1'b1;
        timer_b2_thin_irq <= 1'b0;
        timer_a0_irq <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* sar_adc_sequencer_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_cfg.svh"

module sar_adc_sequencer_control_tb;
    import adc_seq_pkg::*;
    typedef struct {logic [2:0] idx; logic [9:0] val; logic dma; logic ckirq;} note_t;
    logic mclk, rstn, ext_trigger_pin, timer_b2_thin_irq, timer_a0_irq, comparator_out;
    logic multiport_ctrl_in, conv_start, busy, ref_connected, conv_clk_en, sampling;
    logic result_wr, conv_irq, dma_req, multiport_ctrl_out;
    logic [9:0] dac_code;
    logic [9:0] result [`NUM_RESULTS];
    logic [9:0] level [8];
    logic [2:0] result_wr_idx;
    adc_ctrl_t ctrl;
    adc_sel_t sel;
    note_t q[$];
    int fail_count = 0;
    int comparisons = 0;
    int cycle = 0;
    int divs [8] = '{4, 3, 2, 1, 8, 6, 8, 8};
    logic [31:0] seed = 32'h0000_4571;

    sar_adc_sequencer_control DUT (.mclk(mclk), .rstn(rstn), .ctrl(ctrl),
        .ext_trigger_pin(ext_trigger_pin), .timer_b2_thin_irq(timer_b2_thin_irq),
        .timer_a0_irq(timer_a0_irq), .comparator_out(comparator_out),
        .multiport_ctrl_in(multiport_ctrl_in), .conv_start(conv_start), .busy(busy),
        .ref_connected(ref_connected), .conv_clk_en(conv_clk_en), .sampling(sampling),
        .sel(sel), .dac_code(dac_code), .result(result), .result_wr_idx(result_wr_idx),
        .result_wr(result_wr), .conv_irq(conv_irq), .dma_req(dma_req),
        .multiport_ctrl_out(multiport_ctrl_out));

    analog_front_model PARTNER (.mclk(mclk), .dac_code(dac_code), .sel(sel), .level(level),
        .comparator_out(comparator_out), .ext_trigger_pin(ext_trigger_pin),
        .timer_b2_thin_irq(timer_b2_thin_irq), .timer_a0_irq(timer_a0_irq));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int cyc_of();
        if (ctrl.sample_hold) begin
            return ctrl.res_10bit ? `CYC_SH_10 : `CYC_SH_8;
        end
        return ctrl.res_10bit ? `CYC_NOSH_10 : `CYC_NOSH_8;
    endfunction

    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_flag(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycle <= cycle + 1;
        if (cycle == 60000) begin
            fail_count++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Monitor: every written result consumes the oldest note
    initial begin
        note_t n;
        forever begin
            @(negedge mclk);
            if (result_wr === 1'b1) begin
                if (q.size() == 0) begin
                    chk_flag("unexpected result_wr", 1'b0, 1'b1);
                end else begin
                    n = q.pop_front();
                    chk("result_wr_idx", {7'h00, n.idx}, {7'h00, result_wr_idx});
                    chk_flag("dma_req", n.dma, dma_req);
                    chk_flag("conv_irq", n.ckirq, conv_irq);
                    chk("result", n.val, result[n.idx]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic pulse(input logic set);
        @(posedge mclk);
        ctrl.conv_start_set <= set;
        ctrl.conv_start_clr <= !set;
        @(posedge mclk);
        ctrl.conv_start_set <= 1'b0;
        ctrl.conv_start_clr <= 1'b0;
    endtask

    task automatic setup(input logic [2:0] dv, input logic [2:0] md, input logic [2:0] pin);
        logic [31:0] r;
        r = rnd();
        @(posedge mclk);
        {ctrl.clk_div_sel_hi, ctrl.clk_div_sel_a, ctrl.clk_div_sel_b} <= dv;
        {ctrl.repeat_sweep1_sel, ctrl.op_mode_hi, ctrl.op_mode_lo} <= md;
        ctrl.channel_sel <= pin;
        ctrl.res_10bit <= r[0];
        ctrl.sample_hold <= r[1];
        ctrl.dma_result_mode <= r[2];
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            level[i] <= r[9:0];
        end
        @(posedge mclk);
    endtask

    task automatic expect_res(input logic [2:0] pin, input logic irq);
        note_t n;
        n.idx = ctrl.dma_result_mode ? 3'h0 : pin;
        n.val = ctrl.res_10bit ? level[pin] : {2'b00, level[pin][9:2]};
        n.dma = ctrl.dma_result_mode;
        n.ckirq = irq;
        q.push_back(n);
    endtask

    task automatic wait_empty(input int t0, output int took);
        while (q.size() != 0 && cycle - t0 < 4000) begin
            @(posedge mclk);
        end
        took = cycle - t0;
        chk_flag("results pending", 1'b0, q.size() != 0);
        q.delete();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int took, cyc, dv, t0, n, smp;
        logic [31:0] r;
        rstn = 1'b0;
        ctrl = '0;
        multiport_ctrl_in = 1'b0;
        for (int i = 0; i < 8; i++) begin
            level[i] = 10'h000;
        end
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        ctrl.ref_connect <= 1'b1;
        pulse(1'b1);
        repeat (20) @(posedge mclk);
        chk_flag("busy before settle", 1'b0, busy);
        chk_flag("ref_connected", 1'b1, ref_connected);
        pulse(1'b0);
        repeat (`REF_SETTLE_CYC) @(posedge mclk);
        $display("Test reference settle done");

        for (int k = 0; k < 12; k++) begin
            r = rnd();
            setup(3'(k % 6), MODE_ONE_SHOT, r[2:0]);
            expect_res(r[2:0], 1'b1);
            cyc = cyc_of();
            dv = divs[k % 6];
            smp = ctrl.sample_hold ? `SMP_SH : `SMP_NOSH;
            @(negedge mclk);
            while (conv_clk_en !== 1'b1) @(negedge mclk);
            t0 = cycle;
            @(negedge mclk);
            while (conv_clk_en !== 1'b1) @(negedge mclk);
            chk("tick period", 10'(dv), 10'(cycle - t0));
            t0 = cycle;
            pulse(1'b1);
            n = 0;
            @(negedge mclk);
            while (sampling === 1'b1) begin
                n++;
                @(negedge mclk);
            end
            chk_flag("sampling", 1'b1, n > (smp - 1) * dv && n <= smp * dv);
            wait_empty(t0, took);
            chk_flag("conversion time", 1'b1, took >= (cyc - 1) * dv && took <= (cyc + 1) * dv + 8);
            repeat (2) @(posedge mclk);
            chk_flag("conv_start cleared", 1'b0, conv_start);
        end
        $display("Test one-shot dividers done");

        setup(3'h3, MODE_ONE_SHOT, 3'h2);
        pulse(1'b1);
        repeat (20) @(posedge mclk);
        pulse(1'b0);
        repeat (4) @(posedge mclk);
        chk_flag("busy after abort", 1'b0, busy);
        repeat (600) @(posedge mclk);
        $display("Test abort done");

        for (int s = 0; s < 3; s++) begin
            r = rnd();
            setup(3'h3, MODE_ONE_SHOT, r[2:0]);
            {ctrl.trigger_source_hi, ctrl.trigger_source_lo} <= 2'(s);
            @(posedge mclk);
            ctrl.trigger_type_sel <= 1'b1;
            pulse(1'b1);
            repeat (10) @(posedge mclk);
            chk_flag("idle until trigger", 1'b0, busy);
            expect_res(r[2:0], 1'b1);
            cyc = cyc_of();
            PARTNER.fire(2'(s));
            repeat (12) @(posedge mclk);
            t0 = cycle;
            PARTNER.fire(2'(s));
            wait_empty(t0, took);
            chk_flag("retrigger time", 1'b1, took >= cyc - 1 && took <= cyc + 14);
            pulse(1'b0);
            ctrl.trigger_type_sel <= 1'b0;
        end
        $display("Test triggers done");

        setup(3'h3, MODE_SWEEP, 3'h5);
        ctrl.dma_result_mode <= 1'b0;
        @(posedge mclk);
        expect_res(3'h0, 1'b0);
        expect_res(3'h1, 1'b0);
        pulse(1'b1);
        wait_empty(cycle, took);
        pulse(1'b0);
        $display("Test single sweep done");

        setup(3'h3, MODE_SWEEP, 3'h0);
        ctrl.dma_result_mode <= 1'b1;
        {ctrl.port_group_hi, ctrl.port_group_lo} <= 2'b01;
        {ctrl.sweep_range_hi, ctrl.sweep_range_lo} <= 2'b11;
        @(posedge mclk);
        ctrl.multiport_sweep_en <= 1'b1;
        multiport_ctrl_in <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 16; i++) begin
            expect_res(3'(i % 8), 1'b0);
        end
        repeat (3) @(posedge mclk);
        chk_flag("multiport_ctrl_out", 1'b1, multiport_ctrl_out);
        pulse(1'b1);
        repeat (4) @(posedge mclk);
        chk("sel.port", 10'h001, {8'h00, sel.port});
        wait_empty(cycle, took);
        pulse(1'b0);
        ctrl.multiport_sweep_en <= 1'b0;
        repeat (3) @(posedge mclk);
        chk_flag("multiport_ctrl_out", 1'b0, multiport_ctrl_out);
        multiport_ctrl_in <= 1'b0;
        ctrl.ref_connect <= 1'b0;
        repeat (2) @(posedge mclk);
        chk_flag("ref_connected", 1'b0, ref_connected);
        $display("Test multi-port sweep done");
        conclude();
    end
endmodule

`default_nettype wire
